// >>> rtl/spm_consts.svh
// Offsets, field positions, reset values and timing counts of the serial port
//
// Overview of operation
// - Interrupt when complete, enabled and globally enabled
// - Nothing operates unless port enable set
// - Bit order one shifts LSB first
// - Role select one means master, zero slave
// - Select low in master: drop role, flag
// - Polarity sets serial clock idle level
// - Phase picks sample and setup edges
// - Rate bits matter only as master
// - Divide by 4/16/64/128, doubled: 2/8/32/64
// - Byte finished sets transfer complete flag
// - Vector or status-then-data access clears flag
// - Data write while busy sets collision
// - Status then data access clears both flags
// - Status bits five to one read zero
// - Double speed bit doubles master clock
// - Data write loads shifter, starts transfer
// - Data read returns receive buffer
// - Master clock stops after eight bits
// - Select high resets slave shift logic
// - Single buffered send, double buffered receive
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH

// Register byte addresses
`define SPM_ADDR_CTRL 8'h30
`define SPM_ADDR_STAT 8'h34
`define SPM_ADDR_DATA 8'h38
`define SPM_ADDR_W 8

// Control field positions
`define SPM_C_IRQEN 7
`define SPM_C_EN 6
`define SPM_C_LSBF 5
`define SPM_C_ROLE_SELECT_BIT 4
`define SPM_C_POLARITY_BIT 3
`define SPM_C_PHASE_BIT 2

// Status field positions
`define SPM_S_TC 7
`define SPM_S_WRITE_COLLISION_FLAG 6
`define SPM_S_DBL 0

// Reset values
`define SPM_CTRL_RST 8'h00
`define SPM_DATA_RST 8'h00

// Half periods of the serial clock in ref_clk cycles for rate codes 0..3
`define SPM_HALF_0 7'h02
`define SPM_HALF_1 7'h08
`define SPM_HALF_2 7'h20
`define SPM_HALF_3 7'h40

// Index of the last of the 16 edges in one byte
`define SPM_LAST_EDGE 4'hF

`endif

// >>> rtl/spm_pkg.sv
// Types shared by the serial port design
package spm_pkg;

    // Master sequencer states
    typedef enum logic [0:0] {
        SPM_IDLE = 1'b0,
        SPM_RUN = 1'b1
    } spm_state_e;

    // Every flip-flop of the port
    typedef struct packed {
        spm_state_e st;
        logic [7:0] ctrl;
        logic dbl;
        logic tc;
        logic write_collision_flag;
        logic armed;
        logic [7:0] sh;
        logic [7:0] rxBuf;
        logic txBit;
        logic sckLvl;
        logic [3:0] edgeCnt;
        logic [6:0] divCnt;
        logic [2:0] sckS;
        logic [1:0] ssS;
        logic [1:0] misoS;
        logic [1:0] mosiS;
        logic rdy;
        logic [31:0] rdata;
        logic slvErr;
        logic irq;
        logic sckOe;
        logic mosiOe;
        logic misoOe;
    } spm_regs_s;

endpackage

// >>> rtl/spm_port.sv
// Byte-wide master/slave serial port with an APB register slave
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "spm_consts.svh"

module spm_port
    import spm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SPM_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Processor side
    input wire logic globalIrqEn,
    input wire logic vectorAck,
    input wire logic ssPinIsInput,
    output logic spiIrq,
    // Serial clock pin
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOe,
    // Master-out pin
    input wire logic mosiIn,
    output logic mosiOut,
    output logic mosiOe,
    // Master-in pin
    input wire logic misoIn,
    output logic misoOut,
    output logic misoOe,
    // Select pin, always an input to the port
    input wire logic ssnIn
);

    ////////////////////////////////////////////////////////////////////////
    // State

    // Present state
    spm_regs_s r;
    // Next state
    spm_regs_s n;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    // Whole port behaviour in one pass
    always_comb
    begin
        logic en;
        logic role_select_bit;
        logic phase_bit;
        logic lsbf;
        logic busy;
        logic mEdge;
        logic sEdge;
        logic inBit;
        logic outBit;
        logic [6:0] half;
        logic [7:0] shNew;
        logic acc;
        logic wr;
        logic rd;
        logic dataAcc;
        logic mapped;
        logic [7:0] rv;
        en = r.ctrl[`SPM_C_EN];
        role_select_bit = r.ctrl[`SPM_C_ROLE_SELECT_BIT];
        phase_bit = r.ctrl[`SPM_C_PHASE_BIT];
        lsbf = r.ctrl[`SPM_C_LSBF];
        busy = (r.st == SPM_RUN) || (r.edgeCnt != 4'h0);
        mEdge = 1'b0;
        sEdge = 1'b0;
        half = `SPM_HALF_0;
        shNew = r.sh;
        rv = 8'h00;
        n = r;

        // Pin synchronisers; logic reads the second stage, and for the serial clock also the third
        n.sckS = {r.sckS[1:0], sckIn};
        n.ssS = {r.ssS[0], ssnIn};
        n.misoS = {r.misoS[0], misoIn};
        n.mosiS = {r.mosiS[0], mosiIn};

        // Rate applies to master divider only
        unique case (r.ctrl[1:0])
            2'b00: half = `SPM_HALF_0;
            2'b01: half = `SPM_HALF_1;
            2'b10: half = `SPM_HALF_2;
            2'b11: half = `SPM_HALF_3;
        endcase
        if (r.dbl)
        begin
            half = half >> 1;
        end

        // Master clock divider runs only while a byte is in flight
        if (r.st == SPM_RUN)
        begin
            if (r.divCnt == half - 7'h01)
            begin
                n.divCnt = 7'h00;
                mEdge = 1'b1;
            end
            else
            begin
                n.divCnt = r.divCnt + 7'h01;
            end
        end

        // Select high resets slave bit counter
        if (!role_select_bit && r.ssS[1])
        begin
            n.edgeCnt = 4'h0;
        end
        else if (!role_select_bit && en)
        begin
            // Slave edges come from the second and third sync stages
            sEdge = r.sckS[1] ^ r.sckS[2];
        end

        outBit = lsbf ? r.sh[0] : r.sh[7];
        inBit = role_select_bit ? r.misoS[1] : r.mosiS[1];

        // First bit presented before leading edge
        if (!phase_bit && r.edgeCnt == 4'h0 && !busy)
        begin
            n.txBit = outBit;
        end

        // Shared edge engine for both roles
        if (mEdge || sEdge)
        begin
            // Sample on even edges when phase zero
            if (r.edgeCnt[0] == phase_bit)
            begin
                shNew = lsbf ? {inBit, r.sh[7:1]} : {r.sh[6:0], inBit};
                n.sh = shNew;
            end
            else
            begin
                n.txBit = outBit;
            end
            // Master clock toggles from idle level
            if (mEdge)
            begin
                n.sckLvl = ~r.sckLvl;
            end
            n.edgeCnt = r.edgeCnt + 4'h1;
            if (r.edgeCnt == `SPM_LAST_EDGE)
            begin
                n.rxBuf = shNew;
                n.tc = 1'b1;
                n.st = SPM_IDLE;
                n.edgeCnt = 4'h0;
            end
        end

        // Serial clock rests at its idle level between bytes
        if (r.st == SPM_IDLE)
        begin
            n.sckLvl = r.ctrl[`SPM_C_POLARITY_BIT];
        end

        ////////////////////////////////////////////////////////////////////
        // APB: answer one cycle into the access phase

        acc = psel && penable && r.rdy;
        wr = acc && pwrite;
        rd = acc && !pwrite;
        mapped = (paddr == `SPM_ADDR_CTRL) || (paddr == `SPM_ADDR_STAT)
            || (paddr == `SPM_ADDR_DATA);
        dataAcc = acc && (paddr == `SPM_ADDR_DATA);

        // Read value is captured on the same edge that raises pready
        unique case (paddr)
            `SPM_ADDR_CTRL: rv = r.ctrl;
            `SPM_ADDR_STAT: rv = {r.tc, r.write_collision_flag, 5'h00, r.dbl};
            `SPM_ADDR_DATA: rv = r.rxBuf;
            default: rv = 8'h00;
        endcase
        n.rdy = psel && penable && !r.rdy;
        if (psel && penable && !r.rdy)
        begin
            n.rdata = {24'h000000, rv};
            n.slvErr = !mapped;
        end
        else if (acc)
        begin
            n.slvErr = 1'b0;
        end

        if (dataAcc && r.armed)
        begin
            n.tc = 1'b0;
            n.write_collision_flag = 1'b0;
            n.armed = 1'b0;
        end
        if (rd && paddr == `SPM_ADDR_STAT && (r.tc || r.write_collision_flag))
        begin
            n.armed = 1'b1;
        end
        if (vectorAck)
        begin
            n.tc = 1'b0;
        end

        // Register writes
        if (wr && paddr == `SPM_ADDR_CTRL)
        begin
            n.ctrl = pwdata[7:0];
        end
        if (wr && paddr == `SPM_ADDR_STAT)
        begin
            n.dbl = pwdata[`SPM_S_DBL];
        end
        if (wr && paddr == `SPM_ADDR_DATA)
        begin
            if (busy)
            begin
                n.write_collision_flag = 1'b1;
            end
            else if (en)
            begin
                n.sh = pwdata[7:0];
                n.edgeCnt = 4'h0;
                // First bit on the line before leading edge
                n.txBit = lsbf ? pwdata[0] : pwdata[7];
                if (role_select_bit)
                begin
                    // Only a master launches the clock
                    n.st = SPM_RUN;
                    n.divCnt = 7'h00;
                end
            end
        end

        // Hardware sets win over the clears above
        if ((mEdge || sEdge) && r.edgeCnt == `SPM_LAST_EDGE)
        begin
            n.tc = 1'b1;
        end

        // Select low while master forces slave role
        if (en && role_select_bit && ssPinIsInput && !r.ssS[1])
        begin
            n.ctrl[`SPM_C_ROLE_SELECT_BIT] = 1'b0;
            n.tc = 1'b1;
            n.st = SPM_IDLE;
            n.edgeCnt = 4'h0;
        end

        if (!en)
        begin
            n.st = SPM_IDLE;
            n.edgeCnt = 4'h0;
            n.divCnt = 7'h00;
        end

        // Pin drivers: master owns clock and master-out, slave owns master-in
        // Pin directions follow the role
        n.sckOe = n.ctrl[`SPM_C_EN] && n.ctrl[`SPM_C_ROLE_SELECT_BIT];
        n.mosiOe = n.ctrl[`SPM_C_EN] && n.ctrl[`SPM_C_ROLE_SELECT_BIT];
        n.misoOe = n.ctrl[`SPM_C_EN] && !n.ctrl[`SPM_C_ROLE_SELECT_BIT] && !r.ssS[1];

        // Interrupt request gated by both enables
        n.irq = n.tc && n.ctrl[`SPM_C_IRQEN] && globalIrqEn;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    // Asynchronous reset to constants only
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            r <= '0;
            r.ctrl <= `SPM_CTRL_RST;
            r.sh <= `SPM_DATA_RST;
            r.rxBuf <= `SPM_DATA_RST;
            r.sckS <= 3'h0;
            r.ssS <= 2'h3;
        end
        else
        begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a flip-flop

    assign prdata = r.rdata;
    assign pready = r.rdy;
    assign pslverr = r.slvErr;
    assign spiIrq = r.irq;
    assign sckOut = r.sckLvl;
    assign sckOe = r.sckOe;
    // Same shift-out bit serves both roles; only the enables differ
    assign mosiOut = r.txBit;
    assign mosiOe = r.mosiOe;
    assign misoOut = r.txBit;
    assign misoOe = r.misoOe;

endmodule
`default_nettype wire

// >>> testbench/spm_port_asserts.sv
// Concurrent checks on the serial port's bus and pins
`timescale 1ns/1ps
`default_nettype none
module spm_port_asserts (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Processor side and pins
    input wire logic globalIrqEn,
    input wire logic ssPinIsInput,
    input wire logic spiIrq,
    input wire logic sckOe,
    input wire logic misoOe,
    input wire logic ssnIn
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    // Access phase not yet answered
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    // Select pin pulled low as an input, past the sync delay
    sequence s_fault;
        (ssPinIsInput && !ssnIn) [*7];
    endsequence
    a_ready_next: assert property (s_wait |=> pready) else $error("no answer");
    a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
    a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits");
    a_irq_gated: assert property (!globalIrqEn |=> !spiIrq) else $error("irq ungated");
    a_one_driver: assert property (sckOe |-> !misoOe) else $error("both roles");
    a_slave_release: assert property (ssnIn [*5] |-> !misoOe) else $error("miso held");
    a_fault_drop: assert property (s_fault |-> !sckOe) else $error("master kept");
endmodule
`default_nettype wire

// >>> testbench/spm_slave_model.sv
// Behavioural serial slave, mode 0, most significant bit first
`timescale 1ns/1ps
`default_nettype none
module spm_slave_model (
    // Pins from the master
    input wire logic sck,
    input wire logic mosi,
    input wire logic ssn,
    // Byte to send and byte seen
    input wire logic [7:0] txByte,
    output logic miso,
    output logic [7:0] rxByte
);
    logic [7:0] sh;
    initial
    begin
        miso = 1'b0;
        rxByte = 8'h00;
    end
    // first bit ready before the leading edge
    always @(negedge ssn)
    begin
        sh = txByte;
        miso = sh[7];
    end
    // sample on the rising leading edge
    always @(posedge sck)
        if (!ssn)
            rxByte = {rxByte[6:0], mosi};
    // next bit set up on the trailing edge
    always @(negedge sck)
        if (!ssn)
        begin
            sh = {sh[6:0], 1'b0};
            miso = sh[7];
        end
    // Released line shows the inverse so stale data never matches
    always @(posedge ssn)
        miso = ~miso;
endmodule
`default_nettype wire

// >>> testbench/tb_spi_master_slave_port.sv
// Self-checking bench for the serial port in master and slave roles
`timescale 1ns/1ps
`default_nettype none
`include "spm_consts.svh"
module tb_spi_master_slave_port;
    logic ref_clk, nrst, psel, penable, pwrite, globalIrqEn, vectorAck, ssPinIsInput, ssnIn, selN, lastErr;
    logic pready, pslverr, spiIrq, sckOut, sckOe, mosiOut, mosiOe, misoOe, miso;
    logic [7:0] paddr, txByte, rxByte;
    logic [31:0] pwdata, prdata, rd;
    logic extSck, extMosi, sckLine, mosiLine, slvMiso;
    // Pins seen by both sides: the port's drive when enabled, the bench's otherwise
    assign sckLine = sckOe ? sckOut : extSck;
    assign mosiLine = mosiOe ? mosiOut : extMosi;
    int hx[4] = '{1, 4, 16, 32};
    int n_mismatch = 0;
    int n_compared = 0;
    spm_port u_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .globalIrqEn(globalIrqEn), .vectorAck(vectorAck), .ssPinIsInput(ssPinIsInput), .spiIrq(spiIrq),
        .sckIn(sckLine), .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiLine), .mosiOut(mosiOut),
        .mosiOe(mosiOe), .misoIn(miso), .misoOut(slvMiso), .misoOe(misoOe), .ssnIn(ssnIn));
    spm_slave_model u_slv (.sck(sckLine), .mosi(mosiLine), .ssn(selN), .txByte(txByte), .miso(miso),
        .rxByte(rxByte));
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One bus transfer; holds the request until ready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
        if (n >= 20)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h0, exp});
    endtask
    // Poll status until the byte is done; this read also arms the flag clear
    task automatic wait_tc;
        int n;
        n = 0;
        do
        begin
            apb(1'b0, `SPM_ADDR_STAT, 8'h00);
            n++;
        end
        while (rd[7] !== 1'b1 && n < 200);
        if (rd[7] !== 1'b1)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    task automatic hold_len(input logic lvl, output int k);
        k = 0;
        while (sckOut === lvl && k < 99)
        begin
            @(posedge ref_clk);
            k++;
        end
    endtask
    task automatic test_regs;
        rd_chk(`SPM_ADDR_CTRL, 8'h00);
        apb(1'b1, `SPM_ADDR_STAT, 8'hFF);
        rd_chk(`SPM_ADDR_STAT, 8'h01);
        apb(1'b1, `SPM_ADDR_STAT, 8'h00);
        rd_chk(8'h3C, 8'h00);
        chk({31'h0, lastErr}, 32'h1);
        apb(1'b1, `SPM_ADDR_DATA, 8'h5A);
        repeat (8) @(posedge ref_clk);
        chk({31'h0, sckOe}, 32'h0);
        apb(1'b1, `SPM_ADDR_CTRL, 8'h59);
        repeat (4) @(posedge ref_clk);
        chk({30'h0, sckOe, sckOut}, 32'h3);
        $display("test_regs done");
    endtask
    task automatic test_master;
        txByte = 8'hC3;
        globalIrqEn <= 1'b1;
        apb(1'b1, `SPM_ADDR_CTRL, 8'hD1);
        @(posedge ref_clk);
        chk({30'h0, sckOe, sckOut}, 32'h2);
        selN <= 1'b0;
        apb(1'b1, `SPM_ADDR_DATA, 8'h1E);
        wait_tc();
        chk({31'h0, spiIrq}, 32'h1);
        vectorAck <= 1'b1;
        @(posedge ref_clk);
        vectorAck <= 1'b0;
        rd_chk(`SPM_ADDR_STAT, 8'h00);
        rd_chk(`SPM_ADDR_DATA, 8'hC3);
        chk({24'h0, rxByte}, 32'h1E);
        selN <= 1'b1;
        @(posedge ref_clk);
        selN <= 1'b0;
        apb(1'b1, `SPM_ADDR_CTRL, 8'h71);
        apb(1'b1, `SPM_ADDR_DATA, 8'h1E);
        apb(1'b1, `SPM_ADDR_DATA, 8'hFF);
        wait_tc();
        chk(rd, 32'hC0);
        rd_chk(`SPM_ADDR_DATA, 8'hC3);
        rd_chk(`SPM_ADDR_STAT, 8'h00);
        chk({24'h0, rxByte}, 32'h78);
        selN <= 1'b1;
        $display("test_master done");
    endtask
    task automatic test_rate;
        int h;
        apb(1'b1, `SPM_ADDR_STAT, 8'h01);
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, `SPM_ADDR_CTRL, 8'h50 | 8'(c));
            apb(1'b1, `SPM_ADDR_DATA, 8'h00);
            hold_len(1'b0, h);
            hold_len(1'b1, h);
            hold_len(1'b0, h);
            chk(32'(h), 32'(hx[c]));
            wait_tc();
            apb(1'b0, `SPM_ADDR_DATA, 8'h00);
        end
        apb(1'b1, `SPM_ADDR_STAT, 8'h00);
        $display("test_rate done");
    endtask
    task automatic test_fault;
        apb(1'b1, `SPM_ADDR_CTRL, 8'h51);
        ssPinIsInput <= 1'b1;
        ssnIn <= 1'b0;
        repeat (8) @(posedge ref_clk);
        ssnIn <= 1'b1;
        rd_chk(`SPM_ADDR_CTRL, 8'h41);
        rd_chk(`SPM_ADDR_STAT, 8'h80);
        ssPinIsInput <= 1'b0;
        $display("test_fault done");
    endtask
    // Port as slave; the bench plays the external master with four-cycle clock phases
    task automatic test_slave;
        logic [7:0] tx, got;
        tx = 8'h3C;
        got = 8'h00;
        apb(1'b1, `SPM_ADDR_CTRL, 8'h43);
        apb(1'b1, `SPM_ADDR_DATA, 8'hA5);
        ssnIn <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk({30'h0, misoOe, mosiOe}, 32'h2);
        for (int i = 7; i >= 0; i--)
        begin
            extMosi <= tx[i];
            repeat (4) @(posedge ref_clk);
            got[i] = slvMiso;
            extSck <= 1'b1;
            repeat (4) @(posedge ref_clk);
            extSck <= 1'b0;
        end
        repeat (4) @(posedge ref_clk);
        chk({24'h0, got}, 32'hA5);
        rd_chk(`SPM_ADDR_STAT, 8'h80);
        rd_chk(`SPM_ADDR_DATA, 8'h3C);
        ssnIn <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk({31'h0, misoOe}, 32'h0);
        $display("test_slave done");
    endtask
    initial
    begin
        {nrst, psel, penable, pwrite, globalIrqEn, vectorAck, ssPinIsInput} = 7'h00;
        {ssnIn, selN} = 2'h3;
        {extSck, extMosi} = 2'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        txByte = 8'h00;
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        test_regs();
        test_master();
        test_rate();
        test_fault();
        test_slave();
        tally_and_finish();
    end
endmodule
bind spm_port spm_port_asserts u_chk (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .globalIrqEn(globalIrqEn),
    .ssPinIsInput(ssPinIsInput), .spiIrq(spiIrq), .sckOe(sckOe), .misoOe(misoOe), .ssnIn(ssnIn));
`default_nettype wire
